/* pkg/amce_pkg.sv */
// constants and types shared by the asynchronous memory cycle engine
package amce_pkg;

    localparam int CNT_W = 6;

    // wide port: 64 data bits, 8 byte lanes, address bits 22..3
    localparam int WIDE_DATA_W = 64;
    localparam int WIDE_BE_W = 8;
    localparam int WIDE_ADDR_MSB = 22;
    localparam int WIDE_ADDR_LSB = 3;

    // narrow port: 16 data bits, 2 byte lanes, address bits 20..1
    localparam int NARROW_DATA_W = 16;
    localparam int NARROW_BE_W = 2;
    localparam int NARROW_ADDR_MSB = 20;
    localparam int NARROW_ADDR_LSB = 1;

    localparam int DEFAULT_NUM_CS = 4;

    // ready looked at from this many cycles before the programmed strobe end
    localparam logic [CNT_W-1:0] RDY_LOOK_CYCLES = 6'h02;
    // strobe ends this many cycles after ready is seen high again
    localparam logic [CNT_W-1:0] RDY_TAIL_CYCLES = 6'h02;
    localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;

    // per chip select timing, all counts in memory clock periods
    typedef struct packed {
        logic [CNT_W-1:0] read_setup_cycles;
        logic [CNT_W-1:0] read_strobe_cycles;
        logic [CNT_W-1:0] read_hold_cycles;
        logic [CNT_W-1:0] write_setup_cycles;
        logic [CNT_W-1:0] write_strobe_cycles;
        logic [CNT_W-1:0] write_hold_cycles;
    } amce_timing_t;

    localparam amce_timing_t TIMING_RESET = '0;

    typedef enum logic [1:0] {
        AMCE_IDLE,
        AMCE_SETUP,
        AMCE_STROBE,
        AMCE_HOLD
    } amce_phase_t;

    // a zero count still gives one cycle
    function automatic logic [CNT_W-1:0] amce_at_least_one(input logic [CNT_W-1:0] n);
        amce_at_least_one = (n == CNT_ZERO) ? CNT_ONE : n;
    endfunction

endpackage

/* hdl/amce_sync_bit.sv */
// two flip-flop level synchroniser
`timescale 1ns/1ps
module amce_sync_bit (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    logic stage1;

    always_ff @(posedge clk) begin
        if (rst) begin
            stage1 <= 1'b0;
            q <= 1'b0;
        end else begin
            stage1 <= d;
            q <= stage1;
        end
    end
endmodule // amce_sync_bit

/* hdl/amce_toggle_cross.sv */
// toggle event crossing: synchronised toggle turned into a one-cycle pulse
`timescale 1ns/1ps
module amce_toggle_cross (
    input wire logic clk,
    input wire logic rst,
    input wire logic tgl_in,
    output logic pulse
);
    logic tgl_sync;
    logic tgl_seen;

    amce_sync_bit u_sync (
        .clk(clk),
        .rst(rst),
        .d(tgl_in),
        .q(tgl_sync)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            tgl_seen <= 1'b0;
        end else begin
            tgl_seen <= tgl_sync;
        end
    end

    assign pulse = tgl_sync ^ tgl_seen;
endmodule // amce_toggle_cross

/* hdl/amce_engine.sv */
// asynchronous memory cycle engine, one port instance (wide or narrow)
//
// Contract
// - ready input passes a two flip-flop synchroniser before use
// - ready ignored until two cycles before strobe end; low ready extends strobe
// - after low ready, strobe ends exactly two cycles after ready seen high
// - ready sampled on rising edge of the memory clock
// - selects valid for read setup cycles before read strobe falls
// - selects held for read hold cycles after read strobe rises
// - selects and write data valid for write setup cycles before write strobe
// - selects and write data held for write hold cycles after write strobe
// - read strobe lasts programmed read strobe count plus ready extension
// - write strobe lasts programmed write strobe count plus ready extension
// - six counts come from the per chip select timing settings
// - every count measured in memory clock periods
// - strobes change only on rising memory clock edges
// - wide port: chip selects, 8 lane enables, address 22..3, 64-bit data
// - narrow port: chip selects, 2 lane enables, address 20..1, 16-bit data
// - shared control pins act as output enable, read and write strobe
// - two instances, 64-bit and 16-bit, set by one parameter
`timescale 1ns/1ps
module amce_engine #(
    parameter bit WIDE_PORT = 1'b1,
    parameter int NUM_CS = amce_pkg::DEFAULT_NUM_CS,
    localparam int DATA_W = WIDE_PORT ? amce_pkg::WIDE_DATA_W : amce_pkg::NARROW_DATA_W,
    localparam int BE_W = WIDE_PORT ? amce_pkg::WIDE_BE_W : amce_pkg::NARROW_BE_W,
    localparam int ADDR_MSB = WIDE_PORT ? amce_pkg::WIDE_ADDR_MSB : amce_pkg::NARROW_ADDR_MSB,
    localparam int ADDR_LSB = WIDE_PORT ? amce_pkg::WIDE_ADDR_LSB : amce_pkg::NARROW_ADDR_LSB,
    localparam int ADDR_W = ADDR_MSB - ADDR_LSB + 1,
    localparam int CS_IDX_W = (NUM_CS > 1) ? $clog2(NUM_CS) : 1
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic mem_clock_out_main,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [CS_IDX_W-1:0] req_cs,
    input wire logic [BE_W-1:0] req_be,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire amce_pkg::amce_timing_t [NUM_CS-1:0] cfg_timing,
    output logic resp_valid,
    output logic [DATA_W-1:0] resp_rdata,
    output logic [NUM_CS-1:0] chip_select_n,
    output logic [BE_W-1:0] byte_lane_enable_n,
    output logic [ADDR_W-1:0] mem_addr_bus,
    output logic output_enable_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    input wire logic [DATA_W-1:0] mem_data_bus_in,
    output logic [DATA_W-1:0] mem_data_bus_out,
    output logic mem_data_bus_oe_n,
    input wire logic async_ready_in
);
    // width set picked by WIDE_PORT, lane and address widths follow

    ////////////////////////////////////////////////////////////////////////////
    // core side: request capture and handshake

    logic req_tgl;
    logic done_pulse_core;
    logic p_write;
    logic [CS_IDX_W-1:0] p_cs;
    logic [BE_W-1:0] p_be;
    logic [ADDR_W-1:0] p_addr;
    logic [DATA_W-1:0] p_wdata;
    amce_pkg::amce_timing_t p_tim;
    logic [DATA_W-1:0] lk_rdata;
    logic done_tgl;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            req_ready <= 1'b1;
            req_tgl <= 1'b0;
        end else if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            req_tgl <= ~req_tgl;
        end else if (done_pulse_core) begin
            req_ready <= 1'b1;
        end
    end

    // payload stays still until the link side reports completion
    always_ff @(posedge core_clk) begin
        if (reset) begin
            p_write <= 1'b0;
            p_cs <= '0;
            p_be <= '0;
            p_addr <= '0;
            p_wdata <= '0;
            p_tim <= amce_pkg::TIMING_RESET;
        end else if (req_valid && req_ready) begin
            p_write <= req_write;
            p_cs <= req_cs;
            p_be <= req_be;
            p_addr <= req_addr;
            p_wdata <= req_wdata;
            p_tim <= cfg_timing[req_cs];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            resp_valid <= 1'b0;
            resp_rdata <= '0;
        end else begin
            resp_valid <= done_pulse_core;
            if (done_pulse_core) begin
                resp_rdata <= lk_rdata;
            end
        end
    end

    amce_toggle_cross u_done_cross (
        .clk(core_clk),
        .rst(reset),
        .tgl_in(done_tgl),
        .pulse(done_pulse_core)
    );

    ////////////////////////////////////////////////////////////////////////////
    // link side: reset, ready and request crossings

    logic lk_rst;
    logic rdy_s;
    logic new_req;

    amce_sync_bit u_rst_sync (
        .clk(mem_clock_out_main),
        .rst(1'b0),
        .d(reset),
        .q(lk_rst)
    );

    // ready sampled on rising memory clock edges through two flops
    amce_sync_bit u_rdy_sync (
        .clk(mem_clock_out_main),
        .rst(lk_rst),
        .d(async_ready_in),
        .q(rdy_s)
    );

    amce_toggle_cross u_req_cross (
        .clk(mem_clock_out_main),
        .rst(lk_rst),
        .tgl_in(req_tgl),
        .pulse(new_req)
    );

    ////////////////////////////////////////////////////////////////////////////
    // link side: phase sequencer

    amce_pkg::amce_phase_t phase;
    logic [amce_pkg::CNT_W-1:0] cnt;
    logic lk_write;
    logic extending;
    logic released;
    amce_pkg::amce_timing_t lk_tim;

    logic start;
    logic setup_end;
    logic stb_win;
    logic stb_stall;
    logic stb_release;
    logic strobe_end;
    logic hold_end;

    assign start = (phase == amce_pkg::AMCE_IDLE) && new_req;
    assign setup_end = (phase == amce_pkg::AMCE_SETUP) && (cnt == amce_pkg::CNT_ONE);
    // ready only counts in the last two programmed strobe cycles
    assign stb_win = (phase == amce_pkg::AMCE_STROBE) && !released
        && (cnt <= amce_pkg::RDY_LOOK_CYCLES);
    assign stb_stall = stb_win && !rdy_s;
    assign stb_release = stb_win && rdy_s && extending;
    assign strobe_end = (phase == amce_pkg::AMCE_STROBE) && (cnt == amce_pkg::CNT_ONE)
        && !stb_stall && !stb_release;
    assign hold_end = (phase == amce_pkg::AMCE_HOLD) && (cnt == amce_pkg::CNT_ONE);

    // counts are in memory clock periods; each phase lasts at least one
    always_ff @(posedge mem_clock_out_main) begin
        if (lk_rst) begin
            phase <= amce_pkg::AMCE_IDLE;
            cnt <= amce_pkg::CNT_ZERO;
        end else begin
            unique case (phase)
                amce_pkg::AMCE_IDLE: begin
                    if (start) begin
                        phase <= amce_pkg::AMCE_SETUP;
                        cnt <= amce_pkg::amce_at_least_one(p_write ?
                            p_tim.write_setup_cycles : p_tim.read_setup_cycles);
                    end
                end
                amce_pkg::AMCE_SETUP: begin
                    if (setup_end) begin
                        phase <= amce_pkg::AMCE_STROBE;
                        cnt <= amce_pkg::amce_at_least_one(lk_write ?
                            lk_tim.write_strobe_cycles : lk_tim.read_strobe_cycles);
                    end else begin
                        cnt <= cnt - amce_pkg::CNT_ONE;
                    end
                end
                amce_pkg::AMCE_STROBE: begin
                    if (stb_release) begin
                        cnt <= amce_pkg::RDY_TAIL_CYCLES;
                    end else if (stb_stall) begin
                        cnt <= cnt;
                    end else if (strobe_end) begin
                        phase <= amce_pkg::AMCE_HOLD;
                        cnt <= amce_pkg::amce_at_least_one(lk_write ?
                            lk_tim.write_hold_cycles : lk_tim.read_hold_cycles);
                    end else begin
                        cnt <= cnt - amce_pkg::CNT_ONE;
                    end
                end
                amce_pkg::AMCE_HOLD: begin
                    if (hold_end) begin
                        phase <= amce_pkg::AMCE_IDLE;
                        cnt <= amce_pkg::CNT_ZERO;
                    end else begin
                        cnt <= cnt - amce_pkg::CNT_ONE;
                    end
                end
            endcase
        end
    end

    // access attributes held for the whole access
    always_ff @(posedge mem_clock_out_main) begin
        if (lk_rst) begin
            lk_write <= 1'b0;
            lk_tim <= amce_pkg::TIMING_RESET;
        end else if (start) begin
            lk_write <= p_write;
            lk_tim <= p_tim;
        end
    end

    // ready extension bookkeeping
    always_ff @(posedge mem_clock_out_main) begin
        if (lk_rst) begin
            extending <= 1'b0;
            released <= 1'b0;
        end else if (start) begin
            extending <= 1'b0;
            released <= 1'b0;
        end else if (stb_stall) begin
            extending <= 1'b1;
        end else if (stb_release) begin
            extending <= 1'b0;
            released <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link side: memory pins

    always_ff @(posedge mem_clock_out_main) begin
        if (lk_rst || hold_end) begin
            chip_select_n <= '1;
            byte_lane_enable_n <= '1;
            mem_addr_bus <= '0;
            output_enable_n <= 1'b1;
            mem_data_bus_out <= '0;
            mem_data_bus_oe_n <= 1'b1;
        end else if (start) begin
            chip_select_n <= ~(NUM_CS'(1) << p_cs);
            byte_lane_enable_n <= ~p_be;
            mem_addr_bus <= p_addr;
            output_enable_n <= p_write;
            mem_data_bus_out <= p_wdata;
            mem_data_bus_oe_n <= ~p_write;
        end
    end

    // strobes move only on rising memory clock edges
    always_ff @(posedge mem_clock_out_main) begin
        if (lk_rst) begin
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
        end else if (setup_end) begin
            read_strobe_n <= lk_write;
            write_strobe_n <= ~lk_write;
        end else if (strobe_end) begin
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link side: read capture and completion

    always_ff @(posedge mem_clock_out_main) begin
        if (lk_rst) begin
            lk_rdata <= '0;
        end else if (strobe_end && !lk_write) begin
            lk_rdata <= mem_data_bus_in;
        end
    end

    always_ff @(posedge mem_clock_out_main) begin
        if (lk_rst) begin
            done_tgl <= 1'b0;
        end else if (hold_end) begin
            done_tgl <= ~done_tgl;
        end
    end

endmodule // amce_engine

/* test/amce_engine_chk.sv */
// assertion checker for the memory cycle engine
`timescale 1ns/1ps
module amce_engine_chk #(
    parameter bit WIDE_PORT = 1'b1,
    parameter int NUM_CS = amce_pkg::DEFAULT_NUM_CS,
    localparam int DATA_W = WIDE_PORT ? amce_pkg::WIDE_DATA_W : amce_pkg::NARROW_DATA_W,
    localparam int BE_W = WIDE_PORT ? amce_pkg::WIDE_BE_W : amce_pkg::NARROW_BE_W,
    localparam int ADDR_W = WIDE_PORT ? (amce_pkg::WIDE_ADDR_MSB - amce_pkg::WIDE_ADDR_LSB + 1)
        : (amce_pkg::NARROW_ADDR_MSB - amce_pkg::NARROW_ADDR_LSB + 1),
    localparam int CS_IDX_W = (NUM_CS > 1) ? $clog2(NUM_CS) : 1
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic mem_clock_out_main,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_write,
    input wire logic [CS_IDX_W-1:0] req_cs,
    input wire logic [BE_W-1:0] req_be,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire amce_pkg::amce_timing_t [NUM_CS-1:0] cfg_timing,
    input wire logic resp_valid,
    input wire logic [DATA_W-1:0] resp_rdata,
    input wire logic [NUM_CS-1:0] chip_select_n,
    input wire logic [BE_W-1:0] byte_lane_enable_n,
    input wire logic [ADDR_W-1:0] mem_addr_bus,
    input wire logic output_enable_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [DATA_W-1:0] mem_data_bus_in,
    input wire logic [DATA_W-1:0] mem_data_bus_out,
    input wire logic mem_data_bus_oe_n,
    input wire logic async_ready_in
);
    a_strobe_excl: assert property (@(posedge mem_clock_out_main) disable iff (reset)
        read_strobe_n || write_strobe_n) else $error("both strobes low");
    a_rd_setup: assert property (@(posedge mem_clock_out_main) disable iff (reset)
        $fell(read_strobe_n) |-> !$past(output_enable_n) && ($past(chip_select_n) != '1))
        else $error("read strobe without setup");
    a_rd_hold: assert property (@(posedge mem_clock_out_main) disable iff (reset)
        $rose(read_strobe_n) |-> !output_enable_n && $stable(mem_addr_bus))
        else $error("read selects dropped with strobe");
    a_wr_setup: assert property (@(posedge mem_clock_out_main) disable iff (reset)
        $fell(write_strobe_n) |-> !$past(mem_data_bus_oe_n) && $stable(mem_data_bus_out))
        else $error("write data not set up");
    a_wr_hold: assert property (@(posedge mem_clock_out_main) disable iff (reset)
        $rose(write_strobe_n) |-> !mem_data_bus_oe_n && $stable(mem_data_bus_out))
        else $error("write data dropped with strobe");
    a_strobe_in_sel: assert property (@(posedge mem_clock_out_main) disable iff (reset)
        (chip_select_n == '1) |-> read_strobe_n && write_strobe_n)
        else $error("strobe outside selection");
    a_one_select: assert property (@(posedge mem_clock_out_main) disable iff (reset)
        $onehot0(~chip_select_n)) else $error("several chip selects low");
    a_wr_oe_off: assert property (@(posedge mem_clock_out_main) disable iff (reset)
        !write_strobe_n |-> output_enable_n && mem_data_bus_oe_n == 1'b0)
        else $error("output enable during write");
    a_rd_bounded: assert property (@(posedge mem_clock_out_main) disable iff (reset)
        $fell(read_strobe_n) |-> ##[1:300] $rose(read_strobe_n)) else $error("read strobe stuck");
    a_take_busy: assert property (@(posedge core_clk) disable iff (reset)
        req_valid && req_ready |=> !req_ready[*2]) else $error("ready after take");
    a_resp_pulse: assert property (@(posedge core_clk) disable iff (reset)
        $rose(req_ready) |-> resp_valid ##1 !resp_valid) else $error("response not one pulse");
    c_read: cover property (@(posedge mem_clock_out_main) $fell(read_strobe_n));
    c_write: cover property (@(posedge mem_clock_out_main) $fell(write_strobe_n));
    c_wait: cover property (@(posedge mem_clock_out_main) !read_strobe_n && !async_ready_in);
endmodule // amce_engine_chk

bind amce_engine amce_engine_chk #(.WIDE_PORT(WIDE_PORT), .NUM_CS(NUM_CS)) amce_engine_chk_inst (.*);

/* test/amce_mem_model.sv */
// behavioural asynchronous memory with wait-state ready
`timescale 1ns/1ps
module amce_mem_model #(
    parameter int DATA_W = 64,
    parameter int ADDR_W = 20,
    parameter int NUM_CS = 4
) (
    input wire logic mem_clk,
    input wire logic [NUM_CS-1:0] chip_select_n,
    input wire logic [ADDR_W-1:0] mem_addr_bus,
    input wire logic output_enable_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [DATA_W-1:0] mem_data_bus_out,
    input wire logic mem_data_bus_oe_n,
    input wire logic [7:0] wait_cycles,
    output logic [DATA_W-1:0] mem_data_bus_in,
    output logic async_ready_in,
    output logic [DATA_W-1:0] last_wdata
);
    logic [DATA_W-1:0] junk = '0;
    logic [7:0] wcnt = 8'h00;
    logic sel_q = 1'b0;
    // data only while strobed, else a toggling pattern
    assign mem_data_bus_in = (!read_strobe_n && !output_enable_n) ?
        {(DATA_W/16){mem_addr_bus[15:0]}} : junk;
    assign async_ready_in = (wcnt == 8'h00);
    always @(posedge mem_clk) begin
        junk <= ~junk;
        sel_q <= (chip_select_n != '1);
        if ((chip_select_n != '1) && !sel_q) begin
            wcnt <= wait_cycles;
        end else if (wcnt != 8'h00) begin
            wcnt <= wcnt - 8'h01;
        end
        if (!write_strobe_n && !mem_data_bus_oe_n) begin
            last_wdata <= mem_data_bus_out;
        end
    end
endmodule // amce_mem_model

/* test/async_memory_cycle_engine_tb_top.sv */
// self-checking bench for the wide and narrow memory cycle engines
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module async_memory_cycle_engine_tb_top;
    localparam int DW = amce_pkg::WIDE_DATA_W;
    localparam int BW = amce_pkg::WIDE_BE_W;
    localparam int AW = amce_pkg::WIDE_ADDR_MSB - amce_pkg::WIDE_ADDR_LSB + 1;
    localparam int NDW = amce_pkg::NARROW_DATA_W;
    localparam int NBW = amce_pkg::NARROW_BE_W;
    localparam int NAW = amce_pkg::NARROW_ADDR_MSB - amce_pkg::NARROW_ADDR_LSB + 1;
    logic core_clk = 1'b0, mclk = 1'b0, reset = 1'b1, req_valid = 1'b0, req_write = 1'b0;
    logic req_ready, resp_valid, oe_n, rd_n, wr_n, doe_n, rdy, p_sel = 1'b0, p_str = 1'b0;
    logic [1:0] req_cs = 2'h0;
    logic [BW-1:0] req_be = '0, be_n, cap_be;
    logic [AW-1:0] req_addr = '0, addr_bus, cap_addr;
    logic [DW-1:0] req_wdata = '0, resp_rdata, din, dout, last_wdata;
    logic [3:0] cs_n, cap_cs;
    logic cap_oe;
    logic [7:0] wait_cycles = 8'h00;
    logic [31:0] seed = 32'hA880BADE, r;
    amce_pkg::amce_timing_t [3:0] cfg_timing = '0;
    int n_mismatch = 0, num_checks = 0, lcyc = 0, t_cs, t_sf, t_sr, t_cr, len, len2;
    // narrow port signals
    logic n_valid = 1'b0, n_write = 1'b0, n_ready, n_resp, n_oe, n_rd, n_wr, n_doe, n_rdy;
    logic [1:0] n_cs = 2'h0;
    logic [NBW-1:0] n_be = '0, n_be_n;
    logic [NAW-1:0] n_addr = '0, n_addr_bus;
    logic [NDW-1:0] n_wdata = '0, n_rdata, n_din, n_dout, n_last;
    logic [3:0] n_cs_n;

    initial forever #5 core_clk = ~core_clk;
    initial begin
        #3;
        forever #16 mclk = ~mclk;
    end

    amce_engine #(.WIDE_PORT(1'b1), .NUM_CS(4)) amce_engine_inst (.core_clk(core_clk),
        .reset(reset), .mem_clock_out_main(mclk), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_cs(req_cs), .req_be(req_be),
        .req_addr(req_addr), .req_wdata(req_wdata), .cfg_timing(cfg_timing),
        .resp_valid(resp_valid), .resp_rdata(resp_rdata), .chip_select_n(cs_n),
        .byte_lane_enable_n(be_n), .mem_addr_bus(addr_bus), .output_enable_n(oe_n),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n), .mem_data_bus_in(din),
        .mem_data_bus_out(dout), .mem_data_bus_oe_n(doe_n), .async_ready_in(rdy));
    amce_mem_model #(.DATA_W(DW), .ADDR_W(AW), .NUM_CS(4)) amce_mem_model_inst (
        .mem_clk(mclk), .chip_select_n(cs_n), .mem_addr_bus(addr_bus),
        .output_enable_n(oe_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .mem_data_bus_out(dout), .mem_data_bus_oe_n(doe_n), .wait_cycles(wait_cycles),
        .mem_data_bus_in(din), .async_ready_in(rdy), .last_wdata(last_wdata));
    amce_engine #(.WIDE_PORT(1'b0), .NUM_CS(4)) amce_engine_n_inst (.core_clk(core_clk),
        .reset(reset), .mem_clock_out_main(mclk), .req_valid(n_valid), .req_ready(n_ready),
        .req_write(n_write), .req_cs(n_cs), .req_be(n_be), .req_addr(n_addr),
        .req_wdata(n_wdata), .cfg_timing(cfg_timing), .resp_valid(n_resp),
        .resp_rdata(n_rdata), .chip_select_n(n_cs_n), .byte_lane_enable_n(n_be_n),
        .mem_addr_bus(n_addr_bus), .output_enable_n(n_oe), .read_strobe_n(n_rd),
        .write_strobe_n(n_wr), .mem_data_bus_in(n_din), .mem_data_bus_out(n_dout),
        .mem_data_bus_oe_n(n_doe), .async_ready_in(n_rdy));
    amce_mem_model #(.DATA_W(NDW), .ADDR_W(NAW), .NUM_CS(4)) amce_mem_model_n_inst (
        .mem_clk(mclk), .chip_select_n(n_cs_n), .mem_addr_bus(n_addr_bus),
        .output_enable_n(n_oe), .read_strobe_n(n_rd), .write_strobe_n(n_wr),
        .mem_data_bus_out(n_dout), .mem_data_bus_oe_n(n_doe), .wait_cycles(8'h00),
        .mem_data_bus_in(n_din), .async_ready_in(n_rdy), .last_wdata(n_last));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int ex(input logic [5:0] n);
        return (n == 6'h00) ? 1 : int'(n);
    endfunction

    // link-side phase timer, sampled mid-cycle
    always @(negedge mclk) begin
        lcyc++;
        if ((cs_n != 4'hF) && !p_sel) begin
            t_cs = lcyc;
            cap_be = be_n;
            cap_addr = addr_bus;
            cap_cs = cs_n;
            cap_oe = oe_n;
        end
        if ((cs_n == 4'hF) && p_sel) t_cr = lcyc;
        if (!(rd_n && wr_n) && !p_str) t_sf = lcyc;
        if ((rd_n && wr_n) && p_str) t_sr = lcyc;
        p_sel = (cs_n != 4'hF);
        p_str = !(rd_n && wr_n);
    end

    task automatic access(input logic wr, input logic [1:0] cs, input logic [5:0] s, t, h,
        input logic [7:0] w, output int tlen);
        logic [AW-1:0] a;
        logic [DW-1:0] d;
        logic [BW-1:0] be;
        int n;
        a = AW'(xs());
        d = {xs(), xs()};
        be = BW'(xs());
        @(negedge core_clk);
        for (int i = 0; i < 4; i++) cfg_timing[i] = 36'({xs(), xs()});
        if (wr) {cfg_timing[cs].write_setup_cycles, cfg_timing[cs].write_strobe_cycles,
            cfg_timing[cs].write_hold_cycles} = {s, t, h};
        else {cfg_timing[cs].read_setup_cycles, cfg_timing[cs].read_strobe_cycles,
            cfg_timing[cs].read_hold_cycles} = {s, t, h};
        req_write = wr;
        req_cs = cs;
        req_addr = a;
        req_wdata = d;
        req_be = be;
        wait_cycles = w;
        req_valid = 1'b1;
        @(negedge core_clk);
        req_valid = 1'b0;
        n = 0;
        while (resp_valid !== 1'b1 && n < 5000) begin
            @(negedge core_clk);
            n++;
        end
        `CHK(n < 5000, 1'b1)
        `CHK(t_sf - t_cs, ex(s))
        `CHK(t_cr - t_sr, ex(h))
        tlen = t_sr - t_sf;
        if (w == 8'h00) `CHK(tlen, ex(t))
        `CHK(cap_cs, ~(4'h1 << cs))
        `CHK(cap_be, ~be)
        `CHK(cap_addr, a)
        `CHK(cap_oe, wr)
        if (wr) `CHK(last_wdata, d)
        else `CHK(resp_rdata, {4{a[15:0]}})
    endtask

    // narrow port: pin group and data path of one access
    task automatic nacc(input logic wr, input logic [1:0] cs);
        logic [NAW-1:0] a;
        logic [NDW-1:0] d;
        logic [NBW-1:0] be;
        int n;
        a = NAW'(xs());
        d = NDW'(xs());
        be = NBW'(xs());
        @(negedge core_clk);
        n_write = wr;
        n_cs = cs;
        n_addr = a;
        n_wdata = d;
        n_be = be;
        n_valid = 1'b1;
        @(negedge core_clk);
        n_valid = 1'b0;
        n = 0;
        while (n_cs_n === 4'hF && n < 5000) begin
            @(negedge mclk);
            n++;
        end
        `CHK(n_cs_n, ~(4'h1 << cs))
        `CHK({n_be_n, n_addr_bus, n_oe}, {~be, a, wr})
        while (n_resp !== 1'b1 && n < 5000) begin
            @(negedge core_clk);
            n++;
        end
        `CHK(n < 5000, 1'b1)
        if (wr) `CHK(n_last, d)
        else `CHK(n_rdata, a[15:0])
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        @(negedge core_clk);
        reset = 1'b0;
        repeat (4) @(posedge mclk);
        for (int k = 0; k < 24; k++) begin
            r = xs();
            access(r[0], r[2:1], 6'(r[5:3]), 6'(r[8:6]), 6'(r[11:9]), 8'h00, len);
        end
        access(1'b0, 2'h1, 6'h01, 6'h0C, 6'h01, 8'h03, len);
        `CHK(len, 12)
        access(1'b0, 2'h2, 6'h04, 6'h02, 6'h01, 8'h04, len);
        access(1'b0, 2'h2, 6'h04, 6'h02, 6'h01, 8'h06, len2);
        `CHK(len2 - len, 2)
        `CHK(len > 2, 1'b1)
        access(1'b1, 2'h3, 6'h04, 6'h02, 6'h02, 8'h06, len);
        `CHK(len, len2)
        for (int k = 0; k < 4; k++) begin
            r = xs();
            nacc(r[0], r[2:1]);
        end
        nacc(1'b0, 2'h3);
        nacc(1'b1, 2'h0);
        test_done();
    end

    initial begin
        #500000;
        n_mismatch++;
        test_done();
    end
endmodule // async_memory_cycle_engine_tb_top
